// [src/rxco_pkg.sv]
// Constants, field positions and carrier types of the receive checksum
// offload control block.
// Assumes a single clock domain and a plain command port for software.
// Contract
// - Control read code 2Bh, write code 2Ch.
// - First byte bit0 enables IPv4 header check.
// - First byte bit1 enables IP version check.
// - First byte bit2 enables IPv6 version check.
// - First byte bits3,4 enable IPv4 TCP, UDP.
// - First byte bits5-7 enable ICMP, IGMP, ICMPv6.
// - Second byte bits0-4 enable IPv6 layer-four checks.
// - Second byte bits6:5 reserved, no function.
// - Second byte bit7: partial sum from 14.
// - Third byte bit0: drop bad header sum.
// - Third byte bit1: drop bad IP version.
// - Third byte bit2: drop bad IPv6 version.
// - Third byte bit3: drop bad TCP sum.
// - Third byte bit4: drop bad UDP sum.
// - Third byte bits5-7: drop ICMP, IGMP, ICMPv6.
package rxco_pkg;

    // Command codes and own register addresses
    localparam logic [7:0] CMD_CTRL_READ   = 8'h2B;
    localparam logic [7:0] CMD_CTRL_WRITE  = 8'h2C;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h40;
    localparam logic [7:0] ADDR_IRQ_CLEAR  = 8'h41;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h42;

    // Check enable byte field positions
    localparam int BIT_IPV4_HDR_CHK = 0;
    localparam int BIT_IP_VER_CHK   = 1;
    localparam int BIT_IPV6_VER_CHK = 2;
    localparam int BIT_L4_V4_LSB    = 3;
    // Second byte: layer-four checks over IPv6 and partial mode
    localparam int BIT_L4_V6_LSB    = 0;
    localparam int BIT_PARTIAL_MODE = 7;
    // Drop byte field positions
    localparam int BIT_DROP_HDR     = 0;
    localparam int BIT_DROP_IP_VER  = 1;
    localparam int BIT_DROP_V6_VER  = 2;
    localparam int BIT_DROP_L4_LSB  = 3;

    // Reset values
    localparam logic [7:0]  CHECK_EN_RESET  = 8'h00;
    localparam logic [7:0]  V6_EN_RESET     = 8'h00;
    localparam logic [7:0]  DROP_EN_RESET   = 8'h00;
    localparam logic [7:0]  V6_EN_LIVE_MASK = 8'h9F;
    localparam logic [2:0]  IRQ_RESET       = 3'h0;
    localparam logic [15:0] SUM_RESET       = 16'h0000;

    // Partial sum starts at this byte offset of the frame
    localparam logic [15:0] PARTIAL_START   = 16'h000E;
    localparam logic [15:0] OFFSET_MAX      = 16'hFFFF;

    // Interrupt status bit positions
    localparam int IRQ_DROPPED   = 0;
    localparam int IRQ_FLAGGED   = 1;
    localparam int IRQ_PARTIAL   = 2;

    // Layer-four protocol, one hot, in enable bit order
    typedef struct packed {
        logic icmpv6;
        logic igmp;
        logic icmp;
        logic udp;
        logic tcp;
    } rxco_proto_type;

    // One byte of the receive stream, CRC already stripped
    typedef struct packed {
        logic       valid;
        logic       sof;
        logic       eof;
        logic [7:0] data;
    } rxco_byte_type;

    // Parser verdict, valid beside the last byte
    typedef struct packed {
        logic           is_v4;
        logic           is_v6;
        rxco_proto_type proto;
        logic           hdr_sum_bad;
        logic           version_bad;
        logic           l4_sum_bad;
    } rxco_desc_type;

    // Per-frame result toward the receive header writer
    typedef struct packed {
        logic        done;
        logic        drop;
        logic        hdr_sum_err;
        logic        version_err;
        logic        l4_sum_err;
        logic        partial_valid;
        logic [15:0] partial_sum;
    } rxco_verdict_type;

    // Control register bytes, as seen on the 24-bit data port
    typedef struct packed {
        logic [7:0] drop_en;
        logic [7:0] v6_en;
        logic [7:0] check_en;
    } rxco_ctrl_type;

    // Frame tracking states
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b01,
        ST_FRAME = 2'b10
    } rxco_state_type;

endpackage

// [src/rxco_sum_acc.sv]
// Ones-complement 16-bit sum accumulator over a byte stream.
// Bytes pair high then low; an odd last byte pads a zero low byte.
`timescale 1ns/10ps

module rxco_sum_acc
    import rxco_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic        clear_in,
    input  wire logic        byte_valid_in,
    input  wire logic [7:0]  byte_in,
    input  wire logic        last_in,
    output logic      [15:0] sum_out
);

    // Whole state of the accumulator
    typedef struct packed {
        logic [15:0] acc;
        logic [7:0]  hi;
        logic        odd;
    } rxco_acc_state_type;

    rxco_acc_state_type st_q;       // Registered state
    rxco_acc_state_type st_d;       // Next state

    // End-around carry addition
    function automatic logic [15:0] oc_add(input logic [15:0] a,
                                           input logic [15:0] b);
        logic [16:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[15:0] + {15'h0000, s[16]};
    endfunction

    logic [15:0] word;              // Word formed by this byte
    logic [15:0] total;             // Sum including this byte

    // Next state and running total
    always_comb begin
        st_d  = st_q;
        word  = st_q.odd ? {st_q.hi, byte_in} : {byte_in, 8'h00};
        total = oc_add(st_q.acc, word);
        if (clear_in) begin
            st_d.acc = SUM_RESET;
            st_d.odd = 1'b0;
            st_d.hi  = 8'h00;
        end
        if (byte_valid_in) begin
            if (last_in || st_q.odd) begin
                // Word complete
                st_d.acc = total;
                st_d.odd = 1'b0;
            end else begin
                // Hold high byte
                st_d.hi  = byte_in;
                st_d.odd = 1'b1;
            end
        end
        sum_out = byte_valid_in ? total : st_q.acc;
    end

    // State register
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            st_q <= '{acc: SUM_RESET, hi: 8'h00, odd: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

endmodule

// [src/rxco_top.sv]
// Receive checksum offload control: control registers, per-frame drop
// or flag decision, fixed offset partial sum and interrupt status.
// Assumes an upstream parser that classifies each frame and reports
// header, version and layer-four sum results beside the last byte.
//
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/10ps

module rxco_top
    import rxco_pkg::*;
(
    input  wire logic             clk_in,
    input  wire logic             sys_rst_in,
    input  wire logic [7:0]       addr_in,
    input  wire logic [23:0]      wdata_in,
    input  wire logic             wr_in,
    input  wire logic             rd_in,
    output logic      [23:0]      rdata_out,
    input  wire rxco_byte_type    rx_byte_in,
    input  wire rxco_desc_type    rx_desc_in,
    output rxco_verdict_type      verdict_out,
    output logic                  irq_out
);

    // Whole state of the block
    typedef struct packed {
        rxco_state_type   state;
        rxco_ctrl_type    ctrl;
        logic [15:0]      offset;
        logic [2:0]       irq_status;
        logic [2:0]       irq_enable;
        logic             irq;
        logic [23:0]      rdata;
        rxco_verdict_type verdict;
    } rxco_top_state_type;

    rxco_top_state_type st_q;       // Registered state
    rxco_top_state_type st_d;       // Next state

    // Picks the enable bit of the frame's protocol
    function automatic logic by_proto(input rxco_proto_type p,
                                      input logic [4:0]     bits);
        return |(p & bits);
    endfunction

    // Partial sum accumulator hookup
    logic        acc_clear;         // Start of a new frame
    logic        acc_take;          // Byte lies in summed range
    logic [15:0] acc_sum;           // Running sum with this byte

    // Per-frame decision terms
    logic        in_frame_byte;     // Byte belongs to a frame
    logic        frame_end;         // Last byte of a frame
    logic        hdr_chk;           // Header sum check active
    logic        v4_ver_chk;        // IPv4 version check active
    logic        v6_ver_chk;        // IPv6 version check active
    logic        l4_chk;            // Layer-four check active
    logic        hdr_err;           // Header sum failed
    logic        v4_ver_err;        // IPv4 version failed
    logic        v6_ver_err;        // IPv6 version failed
    logic        l4_err;            // Layer-four sum failed
    logic        drop;              // Frame is discarded
    logic        partial_on;        // Partial sum mode
    logic [15:0] cur_offset;        // Offset of this byte
    logic [2:0]  irq_set;           // Events of this cycle
    logic [2:0]  irq_clr;           // Software clear of this cycle

    // Frame tracking, decision, registers and interrupt
    always_comb begin
        st_d = st_q;

        // Bytes count from a start of frame; stray bytes are ignored
        in_frame_byte = rx_byte_in.valid
                        && (rx_byte_in.sof || st_q.state == ST_FRAME);
        frame_end     = in_frame_byte && rx_byte_in.eof;
        cur_offset    = rx_byte_in.sof ? 16'h0000 : st_q.offset;
        partial_on    = st_q.ctrl.v6_en[BIT_PARTIAL_MODE];
        acc_clear     = rx_byte_in.valid && rx_byte_in.sof;
        // Sum from byte fourteen to the last byte
        acc_take      = in_frame_byte && partial_on
                        && (cur_offset >= PARTIAL_START);

        unique case (st_q.state)
            ST_IDLE: begin
                if (in_frame_byte && !rx_byte_in.eof) begin
                    st_d.state = ST_FRAME;
                end
            end
            ST_FRAME: begin
                if (frame_end) begin
                    st_d.state = ST_IDLE;
                end
            end
        endcase
        if (in_frame_byte && cur_offset != OFFSET_MAX) begin
            st_d.offset = cur_offset + 16'h0001;
        end

        // Header sum check only for IPv4
        hdr_chk    = rx_desc_in.is_v4
                     && st_q.ctrl.check_en[BIT_IPV4_HDR_CHK];
        v4_ver_chk = rx_desc_in.is_v4
                     && st_q.ctrl.check_en[BIT_IP_VER_CHK];
        v6_ver_chk = rx_desc_in.is_v6
                     && st_q.ctrl.check_en[BIT_IPV6_VER_CHK];
        // Layer-four enable by network layer and protocol
        if (rx_desc_in.is_v4) begin
            l4_chk = by_proto(rx_desc_in.proto,
                     st_q.ctrl.check_en[BIT_L4_V4_LSB +: 5]);
        end else if (rx_desc_in.is_v6) begin
            l4_chk = by_proto(rx_desc_in.proto,
                     st_q.ctrl.v6_en[BIT_L4_V6_LSB +: 5]);
        end else begin
            l4_chk = 1'b0;
        end

        // Errors only count where their check is enabled
        hdr_err    = hdr_chk && rx_desc_in.hdr_sum_bad;
        v4_ver_err = v4_ver_chk && rx_desc_in.version_bad;
        v6_ver_err = v6_ver_chk && rx_desc_in.version_bad;
        l4_err     = l4_chk && rx_desc_in.l4_sum_bad;

        // Drop where the failing check's drop bit is set
        drop = (hdr_err && st_q.ctrl.drop_en[BIT_DROP_HDR])
            || (v4_ver_err && st_q.ctrl.drop_en[BIT_DROP_IP_VER])
            || (v6_ver_err && st_q.ctrl.drop_en[BIT_DROP_V6_VER])
            || (l4_err && by_proto(rx_desc_in.proto,
                st_q.ctrl.drop_en[BIT_DROP_L4_LSB +: 5]));

        // Verdict stands one cycle after the last byte
        st_d.verdict      = '0;
        if (frame_end) begin
            st_d.verdict.done = 1'b1;
            st_d.verdict.drop = drop;
            // Forwarded frames carry their error flags
            st_d.verdict.hdr_sum_err = hdr_err && !drop;
            st_d.verdict.version_err = (v4_ver_err || v6_ver_err)
                                       && !drop;
            st_d.verdict.l4_sum_err  = l4_err && !drop;
            st_d.verdict.partial_valid = partial_on;
            st_d.verdict.partial_sum   = partial_on ? acc_sum
                                         : SUM_RESET;
        end

        // Register writes: control on the write code only
        irq_clr = 3'h0;
        if (wr_in) begin
            unique case (addr_in)
                CMD_CTRL_WRITE: begin
                    st_d.ctrl.check_en = wdata_in[7:0];
                    // Reserved bits hold nothing
                    st_d.ctrl.v6_en    = wdata_in[15:8]
                                         & V6_EN_LIVE_MASK;
                    st_d.ctrl.drop_en  = wdata_in[23:16];
                end
                ADDR_IRQ_CLEAR: begin
                    irq_clr = wdata_in[2:0];
                end
                ADDR_IRQ_ENABLE: begin
                    st_d.irq_enable = wdata_in[2:0];
                end
                default: begin
                    // Other addresses ignore writes
                end
            endcase
        end

        // Register reads: answer in the next cycle only
        st_d.rdata = 24'h000000;
        if (rd_in) begin
            unique case (addr_in)
                CMD_CTRL_READ: begin
                    st_d.rdata = st_q.ctrl;
                end
                ADDR_IRQ_STATUS: begin
                    st_d.rdata = {21'h000000, st_q.irq_status};
                end
                ADDR_IRQ_ENABLE: begin
                    st_d.rdata = {21'h000000, st_q.irq_enable};
                end
                default: begin
                    // Unmapped reads return zero
                end
            endcase
        end

        // Sticky events; a new event wins over a clear
        irq_set = 3'h0;
        irq_set[IRQ_DROPPED] = frame_end && drop;
        irq_set[IRQ_FLAGGED] = frame_end && !drop
                               && (hdr_err || v4_ver_err
                                   || v6_ver_err || l4_err);
        irq_set[IRQ_PARTIAL] = frame_end && partial_on;
        st_d.irq_status = (st_q.irq_status & ~irq_clr) | irq_set;
        st_d.irq        = |(st_d.irq_status & st_d.irq_enable);
    end

    // State register
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            st_q.state      <= ST_IDLE;
            st_q.ctrl       <= '{drop_en:  DROP_EN_RESET,
                                 v6_en:    V6_EN_RESET,
                                 check_en: CHECK_EN_RESET};
            st_q.offset     <= 16'h0000;
            st_q.irq_status <= IRQ_RESET;
            st_q.irq_enable <= IRQ_RESET;
            st_q.irq        <= 1'b0;
            st_q.rdata      <= 24'h000000;
            st_q.verdict    <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // Ones-complement sum over the tail of the frame
    rxco_sum_acc u_sum_acc (
        .clk_in        (clk_in),
        .sys_rst_in    (sys_rst_in),
        .clear_in      (acc_clear),
        .byte_valid_in (acc_take),
        .byte_in       (rx_byte_in.data),
        .last_in       (rx_byte_in.eof),
        .sum_out       (acc_sum)
    );

    // Outputs straight from the state register
    assign rdata_out   = st_q.rdata;
    assign verdict_out = st_q.verdict;
    assign irq_out     = st_q.irq;

endmodule

// [tb/rxco_sva.sv]
// Port checker for the receive offload control block.
// Bound to rxco_top from the testbench top file; one clock domain.
`timescale 1ns/10ps

module rxco_sva
    import rxco_pkg::*;
(
    input  wire logic             clk_in,
    input  wire logic             sys_rst_in,
    input  wire logic             rd_in,
    input  wire logic [23:0]      rdata_out,
    input  wire rxco_byte_type    rx_byte_in,
    input  wire rxco_desc_type    rx_desc_in,
    input  wire rxco_verdict_type verdict_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    logic        in_frame_q; // Inside a frame
    logic [15:0] cnt_q;      // Offset of the next byte
    logic        take;       // Byte accepted
    logic        last;       // Accepted end byte
    logic        short_f;    // Frame of 14 bytes or fewer

    assign take    = rx_byte_in.valid && (rx_byte_in.sof || in_frame_q);
    assign last    = take && rx_byte_in.eof;
    assign short_f = rx_byte_in.sof || cnt_q < 16'h000E;

    // Follows the frame position as the block should
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            in_frame_q <= 1'h0;
            cnt_q      <= 16'h0000;
        end else if (take) begin
            in_frame_q <= !rx_byte_in.eof;
            cnt_q      <= rx_byte_in.sof ? 16'h0001 : cnt_q + 16'h0001;
        end
    end

    rdata_idle_a: assert property (!$past(rd_in) |-> rdata_out == 24'h0)
        else $error("read data outside its slot");
    done_time_a: assert property (last |=> verdict_out.done)
        else $error("verdict missing after end byte");
    done_cause_a: assert property (verdict_out.done |-> $past(last))
        else $error("verdict without end byte");
    verdict_idle_a: assert property (!verdict_out.done
        |-> verdict_out == '0) else $error("verdict fields outside done");
    hdr_cause_a: assert property (last && !rx_desc_in.hdr_sum_bad
        |=> !verdict_out.hdr_sum_err) else $error("header flag uncaused");
    ver_cause_a: assert property (last && !rx_desc_in.version_bad
        |=> !verdict_out.version_err) else $error("version flag uncaused");
    l4_cause_a: assert property (last && !rx_desc_in.l4_sum_bad
        |=> !verdict_out.l4_sum_err) else $error("l4 flag uncaused");
    drop_cause_a: assert property (last && !(rx_desc_in.hdr_sum_bad ||
        rx_desc_in.version_bad || rx_desc_in.l4_sum_bad)
        |=> !verdict_out.drop) else $error("drop without error");
    drop_noflag_a: assert property (verdict_out.drop |->
        !(verdict_out.hdr_sum_err || verdict_out.version_err ||
        verdict_out.l4_sum_err)) else $error("flags on dropped frame");
    short_sum_a: assert property (last && short_f
        |=> verdict_out.partial_sum == 16'h0000) else $error("short sum");

    // Main scenarios reached
    cover property (verdict_out.done && verdict_out.drop);
    cover property (verdict_out.done && verdict_out.partial_valid);
    cover property (verdict_out.done && verdict_out.l4_sum_err);
endmodule

// [tb/rxco_mac_model.sv]
// Receive MAC stand-in: plays frames into the offload block.
// Driven by task calls from the testbench; one clock domain.
`timescale 1ns/10ps

module rxco_mac_model
    import rxco_pkg::*;
(
    input  wire logic     clk_in,
    output rxco_byte_type rx_byte_out,
    output rxco_desc_type rx_desc_out
);
    // Quiet stream at time zero
    initial begin
        rx_byte_out = '0;
        rx_desc_out = '0;
    end

    // One frame, CRC already gone; byte k carries k
    task automatic send(input int len, input rxco_desc_type d);
        for (int i = 0; i < len; i++) begin
            @(posedge clk_in);
            rx_byte_out <= {1'h1, i == 0, i == len - 1, i[7:0]};
            rx_desc_out <= (i == len - 1) ? d : ~d;
        end
    endtask

    // Released stream; stale lines turn over
    task automatic idle();
        @(posedge clk_in);
        rx_byte_out <= {3'h0, ~rx_byte_out.data};
        rx_desc_out <= ~rx_desc_out;
    endtask
endmodule

// [tb/testbench.sv]
// Self-checking bench for the receive offload control block.
// Holds the MAC stand-in, the block and its bound checker.
`timescale 1ns/10ps

module testbench
    import rxco_pkg::*;
;
    typedef struct packed {
        logic [23:0] ctrl; // Control word
        logic [9:0]  d;    // Parser verdict
        logic [3:0]  e;    // Drop, hdr, version, l4
    } rxco_row_type;

    logic             clk_in = 1'h0;
    logic             sys_rst_in = 1'h1;
    logic [7:0]       addr_in = 8'h00;
    logic [23:0]      wdata_in = 24'h0;
    logic             wr_in = 1'h0;
    logic             rd_in = 1'h0;
    logic [23:0]      rdata_out;
    rxco_byte_type    rx_byte;
    rxco_desc_type    rx_desc;
    rxco_verdict_type verdict_out;
    logic             irq_out;
    int               failures = 0;
    int               n_compared = 0;
    rxco_desc_type    d;
    logic [23:0]      ctl;
    rxco_row_type     rows [8] = '{
        {24'h000001, 10'h20C, 4'h4}, {24'h010001, 10'h20C, 4'h8},
        {24'h010000, 10'h20C, 4'h0}, {24'h000002, 10'h20A, 4'h2},
        {24'h020002, 10'h20A, 4'h8}, {24'h000004, 10'h112, 4'h2},
        {24'h040004, 10'h112, 4'h8}, {24'h000002, 10'h112, 4'h0}};

    always #5 clk_in = ~clk_in;

    rxco_mac_model mac_inst (.clk_in(clk_in), .rx_byte_out(rx_byte),
        .rx_desc_out(rx_desc));
    rxco_top rxco_top_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
        .rd_in(rd_in), .rdata_out(rdata_out), .rx_byte_in(rx_byte),
        .rx_desc_in(rx_desc), .verdict_out(verdict_out),
        .irq_out(irq_out));

    // Counts and reports one comparison
    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [23:0] v);
        @(posedge clk_in);
        addr_in  <= a;
        wdata_in <= v;
        wr_in    <= 1'h1;
        @(posedge clk_in);
        wr_in    <= 1'h0;
    endtask

    // Read data stand in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [23:0] e);
        @(posedge clk_in);
        addr_in <= a;
        rd_in   <= 1'h1;
        @(posedge clk_in);
        rd_in   <= 1'h0;
        #1 check(rdata_out, e);
    endtask

    // Frame, then verdict in the cycle after its end byte
    task automatic frame(input int len, input rxco_desc_type fd,
                         input logic [3:0] e);
        mac_inst.send(len, fd);
        mac_inst.idle();
        #1 check(24'({verdict_out.done, verdict_out.drop,
            verdict_out.hdr_sum_err, verdict_out.version_err,
            verdict_out.l4_sum_err}), 24'({1'h1, e}));
    endtask

    // Ones-complement sum of byte pairs from offset 14
    function automatic logic [15:0] ref_sum(input int len);
        int acc;
        acc = 0;
        for (int k = 14; k < len; k += 2) begin
            acc += (k << 8) + ((k + 1 < len) ? k + 1 : 0);
        end
        acc = (acc & 32'hFFFF) + (acc >> 16);
        acc = (acc & 32'hFFFF) + (acc >> 16);
        return acc[15:0];
    endfunction

    task automatic wrap_up();
        $display("failures %0d compared %0d", failures, n_compared);
        if (failures == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Cuts a hang short
    initial begin
        #1000000;
        failures++;
        wrap_up();
    end

    initial begin
        repeat (5) @(posedge clk_in);
        sys_rst_in <= 1'h0;
        // Ordinary cases from the table
        for (int r = 0; r < 8; r++) begin
            wr(CMD_CTRL_WRITE, rows[r].ctrl);
            rd(CMD_CTRL_READ, rows[r].ctrl);
            frame(20, rows[r].d, rows[r].e);
        end
        // Each layer-four type, both families, flag and drop
        for (int p = 0; p < 5; p++) begin
            for (int m = 0; m < 4; m++) begin
                ctl = m[0] ? 24'h000100 << p : 24'h000008 << p;
                if (m[1]) ctl |= 24'h080000 << p;
                d = {~m[0], m[0], 5'(5'h01 << p), 3'h1};
                wr(CMD_CTRL_WRITE, ctl);
                frame(20, d, m[1] ? 4'h8 : 4'h1);
                d = {m[0], ~m[0], 5'(5'h01 << p), 3'h1};
                frame(20, d, 4'h0);
            end
        end
        // Reserved bits read back zero
        wr(CMD_CTRL_WRITE, 24'hFFFFFF);
        rd(CMD_CTRL_READ, 24'hFF9FFF);
        // Partial sum with every check off
        wr(CMD_CTRL_WRITE, 24'h008000);
        frame(19, 10'h20F, 4'h0);
        check(24'({verdict_out.partial_valid, verdict_out.partial_sum}),
            24'({1'h1, ref_sum(19)}));
        frame(14, 10'h20F, 4'h0);
        check(24'(verdict_out.partial_sum), 24'h0);
        // Back to back frames, the second of one byte
        wr(CMD_CTRL_WRITE, 24'h000001);
        mac_inst.send(20, 10'h20C);
        frame(1, 10'h20C, 4'h4);
        // Refused and unmapped accesses
        wr(CMD_CTRL_READ, 24'h00FF00);
        rd(CMD_CTRL_READ, 24'h000001);
        rd(CMD_CTRL_WRITE, 24'h0);
        wr(8'h77, 24'hFFFFFF);
        rd(8'h77, 24'h0);
        // Every event kind seen so far, none enabled yet
        rd(ADDR_IRQ_STATUS, 24'h7);
        check(24'(irq_out), 24'h0);
        // Interrupt masked, enabled, then cleared
        wr(ADDR_IRQ_ENABLE, 24'h0);
        wr(ADDR_IRQ_CLEAR, 24'h7);
        wr(CMD_CTRL_WRITE, 24'h010001);
        frame(20, 10'h20C, 4'h8);
        check(24'(irq_out), 24'h0);
        rd(ADDR_IRQ_STATUS, 24'h1);
        wr(ADDR_IRQ_ENABLE, 24'h1);
        @(posedge clk_in);
        #1 check(24'(irq_out), 24'h1);
        rd(ADDR_IRQ_ENABLE, 24'h1);
        wr(ADDR_IRQ_CLEAR, 24'h1);
        @(posedge clk_in);
        #1 check(24'(irq_out), 24'h0);
        rd(ADDR_IRQ_STATUS, 24'h0);
        // Drop and its clear on one edge: the new event stays
        fork
            mac_inst.send(20, 10'h20C);
            begin
                repeat (19) @(posedge clk_in);
                wr(ADDR_IRQ_CLEAR, 24'h1);
            end
        join
        mac_inst.idle();
        rd(ADDR_IRQ_STATUS, 24'h1);
        check(24'(irq_out), 24'h1);
        // Mid-run reset restores every register
        @(posedge clk_in);
        sys_rst_in <= 1'h1;
        repeat (5) @(posedge clk_in);
        sys_rst_in <= 1'h0;
        rd(CMD_CTRL_READ, 24'h0);
        rd(ADDR_IRQ_ENABLE, 24'h0);
        rd(ADDR_IRQ_STATUS, 24'h0);
        wrap_up();
    end
endmodule

bind rxco_top rxco_sva rxco_sva_inst (.clk_in(clk_in),
    .sys_rst_in(sys_rst_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .rx_byte_in(rx_byte_in), .rx_desc_in(rx_desc_in),
    .verdict_out(verdict_out));
